/* sbc_mode_supply_regs.v */
// mode/supply and behaviour control registers of the system basis device
`timescale 1ns/10ps
`include "sbc_mode_supply_map.vh"
module sbc_mode_supply_regs (
    clk,
    rstn,
    ce,
    wr_strobe,
    rd_strobe,
    addr,
    wdata,
    rdata,
    rdata_valid,
    restart_event,
    reg2_overtemp,
    failure_flag_trig,
    soft_reset_req,
    reset_output_pin_n,
    operating_mode,
    secondary_regulator_policy,
    overvoltage_restart_enable,
    main_reset_threshold_select,
    soft_reset_pulse_disable,
    failure_output_software_activate,
    restart_on_first_failure,
    failure_outputs,
    mode_refused
);
    input wire clk;
    input wire rstn;
    input wire ce;
    input wire wr_strobe;
    input wire rd_strobe;
    input wire [6:0] addr;
    input wire [7:0] wdata;
    output reg [7:0] rdata;
    output reg rdata_valid;
    input wire restart_event;
    input wire reg2_overtemp;
    input wire failure_flag_trig;
    output reg soft_reset_req;
    output wire reset_output_pin_n;
    output wire [1:0] operating_mode;
    output wire [1:0] secondary_regulator_policy;
    output wire overvoltage_restart_enable;
    output wire [1:0] main_reset_threshold_select;
    output wire soft_reset_pulse_disable;
    output wire failure_output_software_activate;
    output wire restart_on_first_failure;
    output wire failure_outputs;
    output reg mode_refused;

    // =========================================
    // overtemperature input from the regulator
    wire overtemp_s;
    reg overtemp_d_reg;
    sbc_sync3 u_ot_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .din(reg2_overtemp),
        .dout(overtemp_s)
    );
    wire overtemp_rise = overtemp_s & ~overtemp_d_reg;

    // =========================================
    // register state
    reg [7:0] msc_reg;
    reg [7:0] msc_next;
    reg [7:0] beh_reg;
    reg [7:0] beh_next;
    reg pulse_reg;
    reg soft_next;
    reg refused_next;

    wire wr_msc = wr_strobe && (addr == `SBC_ADDR_MODE_SUPPLY);
    wire wr_beh = wr_strobe && (addr == `SBC_ADDR_BEHAVIOUR);
    wire [1:0] wr_mode = wdata[`SBC_MODE_MSB:`SBC_MODE_LSB];
    wire [1:0] cur_mode = msc_reg[`SBC_MODE_MSB:`SBC_MODE_LSB];

    // stop to sleep through the register port is refused
    wire stop_to_sleep = (cur_mode == `SBC_MODE_STOP) && (wr_mode == `SBC_MODE_SLEEP);

    always @* begin
        msc_next = msc_reg;
        beh_next = beh_reg;
        soft_next = 1'b0;
        refused_next = 1'b0;
        if (wr_msc) begin
            msc_next = wdata & `SBC_MSC_MASK;
            if (stop_to_sleep) begin
                msc_next[`SBC_MODE_MSB:`SBC_MODE_LSB] = cur_mode;
                refused_next = 1'b1;
            end else if (wr_mode == `SBC_MODE_SOFTRST) begin
                soft_next = 1'b1;
            end
        end
        if (wr_beh) begin
            beh_next = wdata & `SBC_BEH_MASK;
        end
        if (overtemp_rise) begin
            msc_next[`SBC_REG2_MSB:`SBC_REG2_LSB] = `SBC_REG2_OFF;
        end
        if (restart_event) begin
            msc_next = msc_reg & `SBC_MSC_RESTART_KEEP;
            beh_next = beh_reg & `SBC_BEH_RESTART_KEEP;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            msc_reg <= `SBC_MSC_RESET;
            beh_reg <= `SBC_BEH_RESET;
            overtemp_d_reg <= 1'b0;
            soft_reset_req <= 1'b0;
            pulse_reg <= 1'b0;
            mode_refused <= 1'b0;
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
        end else if (ce) begin
            overtemp_d_reg <= overtemp_s;
            mode_refused <= refused_next;
            soft_reset_req <= soft_next;
            pulse_reg <= soft_next & ~beh_reg[`SBC_SRPD_BIT];
            rdata_valid <= wr_strobe | rd_strobe;
            if (soft_next) begin
                msc_reg <= `SBC_MSC_RESET;
                beh_reg <= `SBC_BEH_RESET;
            end else begin
                msc_reg <= msc_next;
                beh_reg <= beh_next;
            end
            // answer shows content before this write
            if (addr == `SBC_ADDR_MODE_SUPPLY) begin
                rdata <= msc_reg;
            end else if (addr == `SBC_ADDR_BEHAVIOUR) begin
                rdata <= beh_reg;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // =========================================
    // field outputs
    assign operating_mode = msc_reg[`SBC_MODE_MSB:`SBC_MODE_LSB];
    assign secondary_regulator_policy = msc_reg[`SBC_REG2_MSB:`SBC_REG2_LSB];
    assign overvoltage_restart_enable = msc_reg[`SBC_OV_BIT];
    assign main_reset_threshold_select = msc_reg[`SBC_RT_MSB:`SBC_RT_LSB];
    assign soft_reset_pulse_disable = beh_reg[`SBC_SRPD_BIT];
    assign failure_output_software_activate = beh_reg[`SBC_FOSW_BIT];
    assign restart_on_first_failure = beh_reg[`SBC_CFG_BIT];
    assign reset_output_pin_n = ~pulse_reg;
    // failure flag keeps outputs on whatever bit 5 says
    assign failure_outputs = beh_reg[`SBC_FOSW_BIT] | failure_flag_trig;
endmodule

/* sbc_mode_supply_map.vh */
// constants of the mode and behaviour control registers
// Function
// - mode field codes; 11 runs soft reset
// - secondary regulator policy codes in bits 4:3
// - bit 2 enables restart on overvoltage
// - bits 1:0 select main reset threshold
// - mode register zero on reset, restart keeps 1:0
// - refuse spi stop to sleep transition
// - restart rewrites mode field to normal
// - restart or overtemperature forces regulator off
// - write answer returns previous register content
// - reserved bits always read zero
// - bit 6 set suppresses reset pulse
// - bit 5 activates failure outputs by software
// - clearing bit 5 keeps failure-triggered outputs
// - restart clears bit 5, outputs released unless failure flag set
// - bit 0 picks first or second failure
// - behaviour register zero, restart keeps 6,0
// - only hardware-modifiable fields change by logic
`ifndef SBC_MODE_SUPPLY_MAP_VH
`define SBC_MODE_SUPPLY_MAP_VH
`define SBC_ADDR_MODE_SUPPLY 7'h01
`define SBC_ADDR_BEHAVIOUR 7'h02
`define SBC_MODE_MSB 7
`define SBC_MODE_LSB 6
`define SBC_REG2_MSB 4
`define SBC_REG2_LSB 3
`define SBC_OV_BIT 2
`define SBC_RT_MSB 1
`define SBC_RT_LSB 0
`define SBC_SRPD_BIT 6
`define SBC_FOSW_BIT 5
`define SBC_CFG_BIT 0
`define SBC_MODE_NORMAL 2'h0
`define SBC_MODE_SLEEP 2'h1
`define SBC_MODE_STOP 2'h2
`define SBC_MODE_SOFTRST 2'h3
`define SBC_REG2_OFF 2'h0
`define SBC_MSC_RESET 8'h00
`define SBC_BEH_RESET 8'h00
`define SBC_MSC_MASK 8'hdf
`define SBC_BEH_MASK 8'h61
`define SBC_MSC_RESTART_KEEP 8'h03
`define SBC_BEH_RESTART_KEEP 8'h41
`endif

/* sbc_sync3.v */
// three stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sbc_sync3 (
    clk,
    rstn,
    ce,
    din,
    dout
);
    input wire clk;
    input wire rstn;
    input wire ce;
    input wire din;
    output reg dout;
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

/* sbc_regs_monitor.sv */
// assertion checker of the control register block
`timescale 1ns/10ps
module sbc_regs_monitor (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire wr_strobe,
    input wire [6:0] addr,
    input wire [7:0] wdata,
    input wire rdata_valid,
    input wire restart_event,
    input wire failure_flag_trig,
    input wire soft_reset_req,
    input wire reset_output_pin_n,
    input wire [1:0] operating_mode,
    input wire [1:0] secondary_regulator_policy,
    input wire failure_output_software_activate,
    input wire failure_outputs,
    input wire mode_refused
);
// ========
// checks
default clocking dc @(posedge clk);
endclocking
default disable iff (!rstn);
sequence s_wr1;
    ce && wr_strobe && addr == 7'h01 && !restart_event;
endsequence
sequence s_stop_sleep;
    operating_mode == 2'h2 ##0 s_wr1 ##0 wdata[7:6] == 2'h1;
endsequence
a_write_answer: assert property (ce && wr_strobe |=> rdata_valid)
    else $error("no answer");
a_refuse_keep: assert property (s_stop_sleep |=> mode_refused && operating_mode == 2'h2)
    else $error("sleep taken");
a_normal_write: assert property (s_wr1 ##0 wdata[7:6] == 2'h0 |=> operating_mode == 2'h0)
    else $error("mode not normal");
a_restart_clear: assert property (ce && restart_event |=> operating_mode == 2'h0
    && secondary_regulator_policy == 2'h0 && !failure_output_software_activate)
    else $error("restart fields");
a_soft_pulse: assert property (soft_reset_req |-> operating_mode == 2'h0 ##1 !soft_reset_req)
    else $error("soft pulse");
a_pin_cause: assert property (!reset_output_pin_n |-> soft_reset_req)
    else $error("pin low");
a_fo_failure: assert property (failure_flag_trig |-> failure_outputs)
    else $error("fo dropped");
a_fo_idle: assert property (!failure_flag_trig && !failure_output_software_activate |-> !failure_outputs)
    else $error("fo active");
endmodule
bind sbc_mode_supply_regs sbc_regs_monitor mon (.clk, .rstn, .ce, .wr_strobe, .addr, .wdata,
    .rdata_valid, .restart_event, .failure_flag_trig, .soft_reset_req, .reset_output_pin_n,
    .operating_mode, .secondary_regulator_policy, .failure_output_software_activate,
    .failure_outputs, .mode_refused);

/* sbc_host_model.sv */
// host side access model driving the register strobes
`timescale 1ns/10ps
module sbc_host_model (
    input wire clk,
    output reg wr_strobe,
    output reg rd_strobe,
    output reg [6:0] addr,
    output reg [7:0] wdata,
    input wire [7:0] rdata
);
initial {wr_strobe, rd_strobe, addr, wdata} = 17'h0_0000;
// one command: address, access bit, data byte
task acc(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    wr_strobe <= w;
    rd_strobe <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_strobe <= 1'h0;
    rd_strobe <= 1'h0;
    wdata <= ~d;
    #1 q = rdata;
endtask
endmodule

/* sbc_mode_supply_control_regs_bench.sv */
// self-checking bench of the control register block
`timescale 1ns/10ps
module sbc_mode_supply_control_regs_bench;
reg clk = 1'h0;
reg rstn = 1'h0;
reg restart_event = 1'h0;
reg reg2_overtemp = 1'h0;
reg failure_flag_trig = 1'h0;
reg ce = 1'h1;
wire [1:0] mode_seen, pol_seen, thr_seen;
wire ovr_seen, srpd_seen, fosw_seen, first_seen, valid_seen, soft_seen;
wire wr_strobe, rd_strobe, reset_output_pin_n, failure_outputs, mode_refused;
wire [6:0] addr;
wire [7:0] wdata, rdata;
reg [7:0] got;
integer err_total = 0;
integer num_checks = 0;
integer cyc = 0;
always #25 clk = ~clk;
sbc_host_model h (.clk, .wr_strobe, .rd_strobe, .addr, .wdata, .rdata);
sbc_mode_supply_regs uut (.clk, .rstn, .ce, .wr_strobe, .rd_strobe, .addr, .wdata,
    .rdata, .rdata_valid(valid_seen), .restart_event, .reg2_overtemp, .failure_flag_trig,
    .soft_reset_req(soft_seen), .reset_output_pin_n, .operating_mode(mode_seen),
    .secondary_regulator_policy(pol_seen), .overvoltage_restart_enable(ovr_seen),
    .main_reset_threshold_select(thr_seen), .soft_reset_pulse_disable(srpd_seen),
    .failure_output_software_activate(fosw_seen), .restart_on_first_failure(first_seen),
    .failure_outputs, .mode_refused);
// ========
// checking and closing
task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
        err_total = err_total + 1;
        give_verdict;
    end
end
initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h00);
    h.acc(0, 7'h02, 8'h00, got); chk(got, 8'h00);
    h.acc(1, 7'h01, 8'hbf, got); chk(got, 8'h00);
    chk({1'h0, mode_seen, pol_seen, ovr_seen, thr_seen}, 8'h5f);
    chk({7'h0, valid_seen}, 8'h01);
    h.acc(1, 7'h01, 8'h5b, got); chk(got, 8'h9f);
    chk({7'h0, mode_refused}, 8'h01);
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h9b);
    h.acc(1, 7'h02, 8'hff, got); chk({7'h0, failure_outputs}, 8'h01);
    chk({5'h0, srpd_seen, fosw_seen, first_seen}, 8'h07);
    h.acc(0, 7'h02, 8'h00, got); chk(got, 8'h61);
    @(posedge clk) restart_event <= 1'h1;
    @(posedge clk) restart_event <= 1'h0;
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h03);
    h.acc(0, 7'h02, 8'h00, got); chk(got, 8'h41);
    chk({7'h0, failure_outputs}, 8'h00);
    chk({5'h0, srpd_seen, fosw_seen, first_seen}, 8'h05);
    $display("test registers done");
    @(posedge clk) failure_flag_trig <= 1'h1;
    h.acc(1, 7'h02, 8'h20, got);
    h.acc(1, 7'h02, 8'h00, got); chk({7'h0, failure_outputs}, 8'h01);
    @(posedge clk) failure_flag_trig <= 1'h0;
    @(posedge clk) #1 chk({7'h0, failure_outputs}, 8'h00);
    h.acc(1, 7'h01, 8'h0b, got);
    @(posedge clk) reg2_overtemp <= 1'h1;
    repeat (8) @(posedge clk);
    reg2_overtemp <= 1'h0;
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h03);
    @(posedge clk) ce <= 1'h0;
    h.acc(1, 7'h01, 8'h44, got);
    @(posedge clk) ce <= 1'h1;
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h03);
    $display("test hardware updates done");
    h.acc(1, 7'h01, 8'hc0, got); chk({7'h0, reset_output_pin_n}, 8'h00);
    chk({7'h0, soft_seen}, 8'h01);
    h.acc(0, 7'h01, 8'h00, got); chk(got, 8'h00);
    h.acc(1, 7'h02, 8'h40, got);
    h.acc(1, 7'h01, 8'hc0, got); chk({7'h0, reset_output_pin_n}, 8'h01);
    h.acc(0, 7'h02, 8'h00, got); chk(got, 8'h00);
    $display("test soft reset done");
    give_verdict;
end
endmodule
